/* cts_pkg.sv */
// register map, limits, defaults and types of the ct rating setpoint store
package cts_pkg;

    localparam int VW = 12;
    localparam int NV_N = 5;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_PH = 8'h08;
    localparam logic [7:0] REG_EF = 8'h0C;
    localparam logic [7:0] REG_FLC = 8'h10;
    localparam logic [7:0] REG_DISP = 8'h14;
    localparam logic [7:0] REG_ISTAT = 8'h18;
    localparam logic [7:0] REG_IMASK = 8'h1C;
    localparam logic [7:0] REG_TRIP = 8'h20;
    localparam logic [7:0] REG_ALM = 8'h24;
    localparam logic [7:0] REG_ALVL = 8'h28;
    localparam logic [7:0] REG_NVRAW = 8'h2C;

    // field positions
    localparam int CTRL_SENS = 2;
    localparam int CTRL_RECALL = 3;
    localparam int CTRL_CLR = 4;
    localparam int NVRAW_IDX = 16;
    localparam int EV_SAVE = 0;
    localparam int EV_BAD = 1;
    localparam int EV_LOCK = 2;

    localparam logic [1:0] SEL_PH = 2'h0;
    localparam logic [1:0] SEL_EF = 2'h1;
    localparam logic [1:0] SEL_FLC = 2'h2;

    // nonvolatile word slots
    localparam int NV_PH = 0;
    localparam int NV_EF = 1;
    localparam int NV_FLC = 2;
    localparam int NV_TRIP = 3;
    localparam int NV_ALM = 4;

    // ratings in amperes
    localparam logic [VW-1:0] PH_MIN = 12'h014;
    localparam logic [VW-1:0] PH_MAX = 12'h4B0;
    localparam logic [VW-1:0] PH_STEP = 12'h005;
    localparam logic [VW-1:0] EF_MIN = 12'h032;
    localparam logic [VW-1:0] EF_MAX = 12'h7D0;
    localparam logic [VW-1:0] EF_STEP = 12'h032;
    localparam logic [VW-1:0] EF_SENS = 12'h005;
    localparam logic [VW-1:0] FLC_STEP = 12'h001;
    localparam logic [VW-1:0] EXT_LIMIT = 12'h3E7;
    localparam logic [VW-1:0] EXT_DIV = 12'h064;

    // values after reset and after an invalid-data load
    localparam logic [VW-1:0] PH_DEF = 12'h096;
    localparam logic [VW-1:0] EF_DEF = 12'h005;
    localparam logic [VW-1:0] FLC_DEF = 12'h044;
    localparam logic [VW-1:0] TRIP_DEF = 12'h01E;
    localparam logic [6:0] ALM_DEF = 7'h5A;

    localparam logic [6:0] FLC_LO_PCT = 7'h2D;
    localparam logic [6:0] FLC_HI_PCT = 7'h5D;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [VW+7:0] PCT_RND = 20'h00063;
    localparam logic [VW+7:0] PCT_DIV = 20'h00064;
    localparam logic [VW-1:0] CSUM_SEED = 12'hA5A;

    typedef enum logic [1:0] {ST_CHECK, ST_IDLE, ST_EDIT} cts_state_t;

    typedef struct packed {
        logic bad;
        logic ext;
        logic four;
        logic [VW-1:0] val;
    } cts_disp_t;

endpackage : cts_pkg

/* cts_store.sv */
// ct rating setpoint store: keypad editing, nv check and wishbone slave
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cts_store
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic key_up_i,
    input wire logic key_down_i,
    input wire logic key_enter_i,
    input wire logic lock_defeat_i,
    output var cts_pkg::cts_disp_t disp_o,
    output logic trip_o,
    output logic irq_o
);
    import cts_pkg::*;

    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [3:0] pin_s3_q;
    cts_state_t st_q;
    cts_state_t st_d;
    logic [1:0] sel_q;
    logic sens_q;
    logic bad_q;
    logic chk_bad_q;
    logic [VW-1:0] ph_q;
    logic [VW-1:0] ef_q;
    logic [VW-1:0] flc_q;
    logic [VW-1:0] trip_q;
    logic [6:0] alm_q;
    logic [VW-1:0] edit_q;
    logic [VW-1:0] nv_q [NV_N];
    logic [VW-1:0] csum_q;
    logic save_q;
    logic [2:0] istat_q;
    logic [2:0] imask_q;
    logic ack_q;
    logic irq_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    cts_disp_t disp_q;
    cts_disp_t disp_d;
    logic [VW-1:0] lo_v;
    logic [VW-1:0] hi_v;
    logic [VW-1:0] st_v;
    logic [VW-1:0] cur_v;

    function automatic logic [VW-1:0] pct_of(
        input logic [VW-1:0] v,
        input logic [6:0] p,
        input logic up
    );
        logic [VW+7:0] m;
        m = {8'h00, v} * {13'h0000, p};
        if (up)
        begin
            m = m + PCT_RND;
        end
        m = m / PCT_DIV;
        pct_of = m[VW-1:0];
    endfunction : pct_of

    // saturating step, never wraps
    function automatic logic [VW-1:0] step_val(
        input logic [VW-1:0] v,
        input logic [VW-1:0] lo,
        input logic [VW-1:0] hi,
        input logic [VW-1:0] st,
        input logic up
    );
        logic [VW:0] t;
        t = {1'b0, v} + {1'b0, st};
        step_val = (t > {1'b0, hi}) ? hi : t[VW-1:0];
        if (!up)
        begin
            step_val = (v < lo + st) ? lo : v - st;
        end
    endfunction : step_val

    // rotate-xor so swapped words are caught too
    function automatic logic [VW-1:0] csum(input logic [NV_N*VW-1:0] w);
        logic [VW-1:0] c;
        c = CSUM_SEED;
        for (int i = 0; i < NV_N; i++)
        begin
            c = {c[VW-2:0], c[VW-1]} ^ w[i*VW +: VW];
        end
        csum = c;
    endfunction : csum

    wire logic unlocked = pin_s2_q[3];
    wire logic [3:0] pin_rise = pin_s2_q & ~pin_s3_q;
    wire logic k_up = pin_rise[0];
    wire logic k_dn = pin_rise[1];
    wire logic k_ent = pin_rise[2];
    wire logic k_any = |pin_rise[2:0];
    wire logic editing = (st_q == ST_EDIT);
    wire logic do_chk = (st_q == ST_CHECK);
    wire logic commit = editing & k_ent & unlocked;

    wire logic wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    wire logic sw_ok = wb_wr & unlocked;
    wire logic wr_ctrl = wb_wr && (wb_adr_i == REG_CTRL) && !editing;
    wire logic sens_chg = wr_ctrl & unlocked & (wb_dat_i[CTRL_SENS] != sens_q);
    wire logic recall = wr_ctrl & wb_dat_i[CTRL_RECALL];
    wire logic clr_bad = wr_ctrl & unlocked & wb_dat_i[CTRL_CLR];
    wire logic wr_trip = sw_ok && (wb_adr_i == REG_TRIP);
    wire logic wr_alm = sw_ok && (wb_adr_i == REG_ALM);
    wire logic wr_istat = wb_wr && (wb_adr_i == REG_ISTAT);
    wire logic wr_imask = wb_wr && (wb_adr_i == REG_IMASK);
    wire logic [2:0] nv_idx = wb_dat_i[NVRAW_IDX +: 3];
    wire logic wr_nvraw = wb_wr && (wb_adr_i == REG_NVRAW) && (nv_idx < 3'h5);
    wire logic [1:0] sel_in = (wb_dat_i[1:0] > SEL_FLC) ? SEL_FLC : wb_dat_i[1:0];
    wire logic [6:0] alm_in = (wb_dat_i[7:0] > {1'b0, PCT_FULL}) ? PCT_FULL : wb_dat_i[6:0];

    wire logic [NV_N*VW-1:0] nv_flat = {nv_q[4], nv_q[3], nv_q[2], nv_q[1], nv_q[0]};
    wire logic [NV_N*VW-1:0] live_flat = {5'h00, alm_q, trip_q, flc_q, ef_q, ph_q};
    wire logic csum_ok = (csum(nv_flat) == csum_q);
    wire logic [VW-1:0] flc_lo = pct_of(ph_q, FLC_LO_PCT, 1'b1);
    wire logic [VW-1:0] flc_hi = pct_of(ph_q, FLC_HI_PCT, 1'b0);
    wire logic [VW-1:0] flc_new = pct_of(edit_q, FLC_LO_PCT, 1'b1);
    wire logic [VW-1:0] alm_lvl = pct_of(trip_q, alm_q, 1'b0);
    wire logic [VW-1:0] shown = editing ? edit_q : cur_v;
    wire logic [2:0] ev = {k_any & ~unlocked, chk_bad_q, commit | wr_trip | wr_alm};

    // pins from the panel; the second stage feeds logic, the third only the key edge detect
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
        end
        else
        begin
            pin_s1_q <= {lock_defeat_i, key_enter_i, key_down_i, key_up_i};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_CHECK: st_d = ST_IDLE;
            ST_IDLE:
            begin
                if (recall)
                    st_d = ST_CHECK;
                else if (unlocked && (k_up || k_dn))
                    st_d = ST_EDIT;
            end
            ST_EDIT:
            begin
                if (!unlocked || k_ent)
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // limits, step and current value of the selected level
    always_comb
    begin
        lo_v = PH_MIN;
        hi_v = PH_MAX;
        st_v = PH_STEP;
        cur_v = ph_q;
        if (sel_q == SEL_EF)
        begin
            lo_v = sens_q ? EF_SENS : EF_MIN;
            hi_v = sens_q ? EF_SENS : EF_MAX;
            st_v = EF_STEP;
            cur_v = ef_q;
        end
        else if (sel_q == SEL_FLC)
        begin
            lo_v = flc_lo;
            hi_v = flc_hi;
            st_v = FLC_STEP;
            cur_v = flc_q;
        end
    end

    always_comb
    begin
        disp_d.bad = bad_q;
        disp_d.four = editing;
        disp_d.ext = !editing && (shown > EXT_LIMIT);
        disp_d.val = disp_d.ext ? shown / EXT_DIV : shown;
    end

    always_comb
    begin
        rdat_d = 32'h0000_0000;
        if (wb_adr_i == REG_CTRL)
            rdat_d[2:0] = {sens_q, sel_q};
        else if (wb_adr_i == REG_STAT)
            rdat_d[6:0] = {st_q, bad_q, unlocked, sens_q, sel_q};
        else if (wb_adr_i == REG_PH)
            rdat_d[VW-1:0] = ph_q;
        else if (wb_adr_i == REG_EF)
            rdat_d[VW-1:0] = ef_q;
        else if (wb_adr_i == REG_FLC)
            rdat_d[VW-1:0] = flc_q;
        else if (wb_adr_i == REG_DISP)
            rdat_d[VW+2:0] = disp_q;
        else if (wb_adr_i == REG_ISTAT)
            rdat_d[2:0] = istat_q;
        else if (wb_adr_i == REG_IMASK)
            rdat_d[2:0] = imask_q;
        else if (wb_adr_i == REG_TRIP)
            rdat_d[VW-1:0] = trip_q;
        else if (wb_adr_i == REG_ALM)
            rdat_d[6:0] = alm_q;
        else if (wb_adr_i == REG_ALVL)
            rdat_d[VW-1:0] = alm_lvl;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= ST_CHECK;
            sel_q <= SEL_PH;
            edit_q <= PH_DEF;
        end
        else
        begin
            st_q <= st_d;
            if (wr_ctrl)
                sel_q <= sel_in;
            if (!editing)
                edit_q <= cur_v;
            else if (k_up || k_dn)
                edit_q <= step_val(edit_q, lo_v, hi_v, st_v, k_up);
        end
    end

    // settings; a failed check reloads defaults instead of stored words
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ph_q <= PH_DEF;
            ef_q <= EF_DEF;
            flc_q <= FLC_DEF;
            trip_q <= TRIP_DEF;
            alm_q <= ALM_DEF;
            sens_q <= 1'b1;
            bad_q <= 1'b0;
            chk_bad_q <= 1'b0;
        end
        else if (do_chk)
        begin
            if (csum_ok)
            begin
                ph_q <= nv_q[NV_PH];
                ef_q <= nv_q[NV_EF];
                flc_q <= nv_q[NV_FLC];
                trip_q <= nv_q[NV_TRIP];
                alm_q <= nv_q[NV_ALM][6:0];
                sens_q <= (nv_q[NV_EF] == EF_SENS);
            end
            else
            begin
                ph_q <= PH_DEF;
                ef_q <= EF_DEF;
                flc_q <= FLC_DEF;
                trip_q <= TRIP_DEF;
                alm_q <= ALM_DEF;
                sens_q <= 1'b1;
                bad_q <= 1'b1;
                chk_bad_q <= 1'b1;
            end
        end
        else
        begin
            chk_bad_q <= 1'b0;
            if (commit && sel_q == SEL_PH)
            begin
                ph_q <= edit_q;
                flc_q <= flc_new;
            end
            if (commit && sel_q == SEL_EF)
                ef_q <= edit_q;
            if (commit && sel_q == SEL_FLC)
                flc_q <= edit_q;
            if (sens_chg)
            begin
                sens_q <= wb_dat_i[CTRL_SENS];
                ef_q <= wb_dat_i[CTRL_SENS] ? EF_SENS : EF_MIN;
            end
            if (wr_trip)
                trip_q <= wb_dat_i[VW-1:0];
            if (wr_alm)
                alm_q <= alm_in;
            if (clr_bad)
                bad_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            save_q <= 1'b0;
        else
            save_q <= commit | sens_chg | wr_trip | wr_alm | chk_bad_q;
    end

    // nonvolatile image: no reset, it must outlive rst_n_i
    always_ff @(posedge clk_sys_i)
    begin
        if (save_q)
        begin
            for (int i = 0; i < NV_N; i++)
            begin
                nv_q[i] <= live_flat[i*VW +: VW];
            end
            csum_q <= csum(live_flat);
        end
        else if (wr_nvraw)
            nv_q[nv_idx] <= wb_dat_i[VW-1:0];
    end

    // status bits: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            istat_q <= 3'h0;
            imask_q <= 3'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            istat_q <= (istat_q & ~(wr_istat ? wb_dat_i[2:0] : 3'h0)) | ev;
            if (wr_imask)
                imask_q <= wb_dat_i[2:0];
            irq_q <= |(istat_q & imask_q);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            disp_q <= '0;
        end
        else
        begin
            ack_q <= wb_req;
            if (wb_req)
                rdat_q <= rdat_d;
            disp_q <= disp_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign disp_o = disp_q;
    assign trip_o = bad_q;
    assign irq_o = irq_q;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    a_ph_edit_range: assert property (
        editing && sel_q == SEL_PH |-> edit_q >= PH_MIN && edit_q <= PH_MAX
            && (edit_q % PH_STEP) == 12'h000)
        else $error("phase rating out of range or step");
    a_ef_edit_range: assert property (
        editing && sel_q == SEL_EF && !sens_q |-> edit_q >= EF_MIN
            && edit_q <= EF_MAX && (edit_q % EF_STEP) == 12'h000)
        else $error("earth-fault rating out of range or step");
    a_sens_ef_fixed: assert property (
        sens_q |-> ef_q == EF_SENS)
        else $error("sensitive sensor rating not 5 A");
    a_disp_four: assert property (
        editing |=> disp_q.four)
        else $error("edit value not shown in four digits");
    a_disp_back: assert property (
        commit |-> ##2 !disp_q.four)
        else $error("display did not return to three digits");
    a_disp_ext: assert property (
        !editing && shown > EXT_LIMIT |=> disp_q.ext
            && disp_q.val == $past(shown) / EXT_DIV)
        else $error("extended notation wrong");
    a_flc_range: assert property (
        !do_chk |-> flc_q >= flc_lo && flc_q <= flc_hi)
        else $error("full-load current outside allowed band");
    a_flc_bottom: assert property (
        commit && sel_q == SEL_PH |=> flc_q == flc_lo)
        else $error("full-load current not at bottom after rating entry");
    a_nv_save: assert property (
        commit |-> ##2 nv_q[NV_PH] == ph_q && csum_ok)
        else $error("setting not stored");
    a_bad_load: assert property (
        chk_bad_q |-> bad_q && ph_q == PH_DEF && ef_q == EF_DEF ##1 disp_q.bad)
        else $error("invalid data did not trip with defaults");
    a_lock_hold: assert property (
        !unlocked && !do_chk |=> $stable(ph_q) && $stable(ef_q)
            && $stable(trip_q) && $stable(alm_q))
        else $error("setting changed under lockout");
    a_step_clamp: assert property (
        editing && !k_ent && k_up && edit_q == hi_v |=> $stable(edit_q))
        else $error("value stepped past its limit");
    a_alarm_pct: assert property (
        alm_q == PCT_FULL |-> alm_lvl == trip_q)
        else $error("alarm level not a percentage of trip");

    c_ph_commit: cover property (commit && sel_q == SEL_PH);
    c_bad_trip: cover property (chk_bad_q);
    c_ext_disp: cover property (disp_q.ext);
    c_clamp_hit: cover property (editing && k_up && edit_q == hi_v);

endmodule : cts_store
`default_nettype wire

/* cts_operator.sv */
// operator model: keypad presses and lockout jumper at the front panel
`timescale 1ns/1ps
`default_nettype none
module cts_operator
(
    input wire logic clk_sys_i,
    output logic key_up_o,
    output logic key_down_o,
    output logic key_enter_o,
    output logic lock_defeat_o
);
    initial
    begin
        key_up_o = 1'b0;
        key_down_o = 1'b0;
        key_enter_o = 1'b0;
        lock_defeat_o = 1'b0;
    end
    // jumper goes on before any programming, off again to lock
    task automatic jumper(input logic v);
        @(posedge clk_sys_i);
        lock_defeat_o <= v;
        // the unit sees the jumper only after its two sync stages
        repeat (3) @(posedge clk_sys_i);
    endtask : jumper
    // pin high 4 cycles, then low long enough for a commit to settle;
    // the level being edited is picked over the bus beforehand
    task automatic press(input logic [1:0] k, input int n);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            key_up_o <= (k == 2'h0);
            key_down_o <= (k == 2'h1);
            key_enter_o <= (k == 2'h2);
            repeat (4) @(posedge clk_sys_i);
            key_up_o <= 1'b0;
            key_down_o <= 1'b0;
            key_enter_o <= 1'b0;
            repeat (6) @(posedge clk_sys_i);
        end
    endtask : press
endmodule : cts_operator
`default_nettype wire

/* testbench.sv */
// self-checking bench for the ct rating setpoint store
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cts_pkg::*;
    localparam logic [1:0] UP = 2'h0;
    localparam logic [1:0] DN = 2'h1;
    localparam logic [1:0] EN = 2'h2;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack, k_up, k_dn, k_en, lock_off, trip, irq;
    cts_disp_t disp;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    cts_store cts_store_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .key_up_i(k_up), .key_down_i(k_dn),
        .key_enter_i(k_en), .lock_defeat_i(lock_off), .disp_o(disp), .trip_o(trip),
        .irq_o(irq));
    cts_operator cts_operator_i (.clk_sys_i(clk_sys_i), .key_up_o(k_up), .key_down_o(k_dn),
        .key_enter_o(k_en), .lock_defeat_o(lock_off));
    task automatic end_sim;
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // the key sweeps need about 6000 cycles
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
            @(posedge clk_sys_i);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk32(rd, e);
    endtask : rdc
    task automatic settle;
        repeat (4) @(posedge clk_sys_i);
    endtask : settle
    task automatic do_reset;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
    endtask : do_reset
    // blank nonvolatile image at first power-up fails its check
    task automatic t_power_up;
        chk32({31'h0, trip}, 32'h1);
        chk32({31'h0, disp.bad}, 32'h1);
        rdc(REG_PH, 32'h96);
        rdc(REG_EF, 32'h5);
        bus(1'b0, REG_ISTAT, 32'h0);
        chk32({31'h0, rd[1]}, 32'h1);
        cts_operator_i.jumper(1'b1);
        wr(REG_CTRL, 32'h14);
        settle();
        chk32({31'h0, trip}, 32'h0);
    endtask : t_power_up
    // locked: keys and set point writes ignored, key event raises the interrupt
    task automatic t_lockout;
        cts_operator_i.jumper(1'b0);
        wr(REG_ISTAT, 32'h7);
        wr(REG_IMASK, 32'h4);
        wr(REG_TRIP, 32'h50);
        cts_operator_i.press(UP, 1);
        rdc(REG_PH, 32'h96);
        rdc(REG_TRIP, 32'h1E);
        chk32({31'h0, irq}, 32'h1);
        wr(REG_IMASK, 32'h0);
        settle();
        chk32({31'h0, irq}, 32'h0);
        wr(REG_IMASK, 32'h4);
        settle();
        chk32({31'h0, irq}, 32'h1);
        wr(REG_ISTAT, 32'h4);
        settle();
        chk32({31'h0, irq}, 32'h0);
    endtask : t_lockout
    // phase rating: step, clamp at both ends, display formats, full-load reload
    task automatic t_phase;
        cts_operator_i.jumper(1'b1);
        wr(REG_CTRL, 32'h4);
        cts_operator_i.press(UP, 1);
        chk32({17'h0, disp}, 32'h1096);
        cts_operator_i.press(UP, 1);
        cts_operator_i.press(EN, 1);
        rdc(REG_PH, 32'h9B);
        rdc(REG_FLC, 32'h46);
        chk32({17'h0, disp}, 32'h9B);
        cts_operator_i.press(UP, 216);
        chk32({17'h0, disp}, 32'h14B0);
        cts_operator_i.press(EN, 1);
        rdc(REG_PH, 32'h4B0);
        rdc(REG_FLC, 32'h21C);
        chk32({17'h0, disp}, 32'h200C);
        cts_operator_i.press(DN, 242);
        cts_operator_i.press(EN, 1);
        rdc(REG_PH, 32'h14);
        rdc(REG_FLC, 32'h9);
    endtask : t_phase
    // full-load current programmed after the phase rating
    task automatic t_flc;
        wr(REG_CTRL, 32'h6);
        cts_operator_i.press(UP, 1);
        cts_operator_i.press(DN, 1);
        cts_operator_i.press(EN, 1);
        rdc(REG_FLC, 32'h9);
        cts_operator_i.press(UP, 14);
        cts_operator_i.press(EN, 1);
        rdc(REG_FLC, 32'h12);
    endtask : t_flc
    task automatic t_earth;
        wr(REG_CTRL, 32'h1);
        rdc(REG_EF, 32'h32);
        cts_operator_i.press(UP, 3);
        cts_operator_i.press(EN, 1);
        rdc(REG_EF, 32'h96);
        cts_operator_i.press(UP, 45);
        cts_operator_i.press(EN, 1);
        rdc(REG_EF, 32'h7D0);
        chk32({17'h0, disp}, 32'h2014);
        wr(REG_CTRL, 32'h5);
        rdc(REG_EF, 32'h5);
    endtask : t_earth
    task automatic t_alarm;
        wr(REG_TRIP, 32'h1E);
        wr(REG_ALM, 32'h5A);
        rdc(REG_ALVL, 32'h1B);
        rdc(8'h40, 32'h0);
    endtask : t_alarm
    // settings survive a reset; a corrupted word trips and reloads defaults
    task automatic t_nv;
        do_reset();
        chk32({31'h0, trip}, 32'h0);
        rdc(REG_PH, 32'h14);
        rdc(REG_FLC, 32'h12);
        wr(REG_NVRAW, 32'h123);
        wr(REG_CTRL, 32'hC);
        settle();
        chk32({31'h0, trip}, 32'h1);
        chk32({31'h0, disp.bad}, 32'h1);
        rdc(REG_PH, 32'h96);
        rdc(REG_EF, 32'h5);
        wr(REG_CTRL, 32'h14);
        settle();
        chk32({31'h0, trip}, 32'h0);
    endtask : t_nv
    initial
    begin
        do_reset();
        t_power_up();
        t_lockout();
        t_phase();
        t_flc();
        t_earth();
        t_alarm();
        t_nv();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
